// ===== hdl/aisc_top.sv
// Analog input status, settling and conversion sequencing, AXI4-Lite slave.
// Assumes converter samples arrive on an asynchronous pin bus; one clock domain.
//
// How it works
// - Writing the channel range raises the settling flag; host waits it out.
// - Range or gain writes in succession restart settling from the last write.
// - Gain code 0..3 selects amplification 1, 2, 4 or 8.
// - Busy reads one during any conversion or sweep, zero when idle.
// - Single mode: busy from conversion start until that conversion ends.
// - Sweep mode: busy stays high across the whole channel range.
// - After overflow the buffer refuses samples until a buffer reset.
// - Overrun flag is sticky until buffer reset.
// - Status reads back the written sweep enable.
// - Status reads back the written gain in its two low bits.
// - Range write resets the channel pointer to the low channel.
// - Sweep samples spaced 10 us, or 5 us with spacing select set.
`timescale 1ns/1ps
`default_nettype none

module aisc_top #(
   parameter int BUF_DEPTH = 48,
   parameter int SAMPLE_W  = 16
) (
   // Clock and reset
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   // AXI4-Lite write
   input  wire logic [aisc_pkg::ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   input  wire logic [31:0]                     s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   output logic [1:0]                           s_axi_bresp,
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   // AXI4-Lite read
   input  wire logic [aisc_pkg::ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   output logic [31:0]                          s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   // Converter pins
   input  wire logic [SAMPLE_W-1:0]             adc_sample,
   input  wire logic                            input_config_indicator_pin,
   output logic                                 conv_start,
   output logic [3:0]                           adc_channel,
   output logic [3:0]                           gain_mult,
   output logic [SAMPLE_W-1:0]                  out_value,
   output logic                                 out_load,
   // Interrupt
   output logic                                 irq
);
   if (BUF_DEPTH < 2 || BUF_DEPTH > 4096 || SAMPLE_W < 1 || SAMPLE_W > 32) begin : g_bad_param
      $error("aisc_top: unsupported parameters");
   end
   if (aisc_pkg::CONV_CYC >= aisc_pkg::SPACE_FAST_CYC) begin : g_bad_timing
      $error("aisc_top: conversion longer than sweep spacing");
   end

   localparam int PW = $clog2(BUF_DEPTH);
   typedef enum logic [1:0] {AISC_IDLE, AISC_CONV, AISC_GAP} aisc_state_t;

   // ==========================================================
   // Pin synchronisers
   logic [SAMPLE_W-1:0] smp_m_r, smp_r;
   logic                se_m_r, se_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         smp_m_r <= '0;
         smp_r   <= '0;
         se_m_r  <= aisc_pkg::SE_RST;
         se_r    <= aisc_pkg::SE_RST;
      end else begin
         smp_m_r <= adc_sample;
         smp_r   <= smp_m_r;
         se_m_r  <= input_config_indicator_pin;
         se_r    <= se_m_r;
      end
   end

   // ==========================================================
   // AXI4-Lite slave: address and data taken in either order
   logic [aisc_pkg::ADDR_W-1:0] aw_addr_r;
   logic [31:0]                 w_data_r;
   logic [3:0]                  w_strb_r;
   logic                        aw_have_r, w_have_r;
   logic                        wr_go;
   logic [3:0]                  wr_idx, rd_idx;
   logic                        wr_ok, rd_ok;
   assign wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wr_idx = aw_addr_r[aisc_pkg::ADDR_W-1:2];
   assign rd_idx = s_axi_araddr[aisc_pkg::ADDR_W-1:2];
   assign wr_ok  = wr_idx inside {aisc_pkg::IDX_CHAN, aisc_pkg::IDX_CTRL, aisc_pkg::IDX_CMD,
                                  aisc_pkg::IDX_IRQ_STAT, aisc_pkg::IDX_IRQ_MASK,
                                  aisc_pkg::IDX_OUT_DATA};
   assign rd_ok  = rd_idx inside {aisc_pkg::IDX_CHAN, aisc_pkg::IDX_STATUS, aisc_pkg::IDX_CTRL,
                                  aisc_pkg::IDX_IRQ_STAT, aisc_pkg::IDX_IRQ_MASK,
                                  aisc_pkg::IDX_DATA};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= '0;
         w_data_r      <= '0;
         w_strb_r      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= aisc_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready;
         s_axi_wready  <= !w_have_r && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? aisc_pkg::RESP_OKAY : aisc_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Byte lane 0 carries register bits, except output data, which is written when any lane is strobed
   logic                   wr_lane0;
   logic                   wr_chan, wr_ctrl, wr_cmd, wr_istat, wr_imask, wr_out;
   assign wr_lane0 = wr_go && w_strb_r[0];
   assign wr_chan  = wr_lane0 && wr_idx == aisc_pkg::IDX_CHAN;
   assign wr_ctrl  = wr_lane0 && wr_idx == aisc_pkg::IDX_CTRL;
   assign wr_cmd   = wr_lane0 && wr_idx == aisc_pkg::IDX_CMD;
   assign wr_istat = wr_lane0 && wr_idx == aisc_pkg::IDX_IRQ_STAT;
   assign wr_imask = wr_lane0 && wr_idx == aisc_pkg::IDX_IRQ_MASK;
   assign wr_out   = wr_go && (w_strb_r != 4'h0) && wr_idx == aisc_pkg::IDX_OUT_DATA;

   // ==========================================================
   // Control registers
   aisc_pkg::aisc_chan_t chan_r;
   aisc_pkg::aisc_ctrl_t ctrl_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_r <= aisc_pkg::CHAN_RST;
         ctrl_r <= aisc_pkg::CTRL_RST;
      end else begin
         if (wr_chan)
            chan_r <= aisc_pkg::aisc_chan_t'(w_data_r[7:0]);
         if (wr_ctrl)
            ctrl_r <= aisc_pkg::aisc_ctrl_t'(w_data_r[3:0]);
      end
   end

   // ==========================================================
   // Settling interval, restarted by every range or gain write
   logic [aisc_pkg::CNT_W-1:0] settle_cnt_r;
   logic                       settling;
   assign settling = settle_cnt_r != '0;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         settle_cnt_r <= '0;
      else if (wr_chan || wr_ctrl)
         settle_cnt_r <= aisc_pkg::CNT_W'(aisc_pkg::SETTLE_CYC);
      else if (settling)
         settle_cnt_r <= settle_cnt_r - 1'b1;
   end

   // ==========================================================
   // Conversion sequencer
   aisc_state_t                state_r;
   logic [aisc_pkg::CNT_W-1:0] seq_cnt_r;
   logic [3:0]                 ptr_r;
   logic                       sweep_run_r;
   logic                       conv_end, start_req, last_ch, run_end;
   logic [3:0]                 ptr_nxt;
   assign start_req = wr_cmd && w_data_r[aisc_pkg::CMD_START] && state_r == AISC_IDLE;
   assign conv_end  = state_r == AISC_CONV && seq_cnt_r == '0;
   assign run_end   = conv_end && (last_ch || !sweep_run_r);
   assign last_ch   = ptr_r == chan_r.high;
   assign ptr_nxt   = last_ch ? chan_r.low : ptr_r + 4'h1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r     <= AISC_IDLE;
         seq_cnt_r   <= '0;
         sweep_run_r <= 1'b0;
      end else begin
         unique case (state_r)
            AISC_IDLE: if (start_req) begin
               state_r     <= AISC_CONV;
               seq_cnt_r   <= aisc_pkg::CNT_W'(aisc_pkg::CONV_CYC - 1);
               sweep_run_r <= ctrl_r.sweep;
            end
            AISC_CONV: if (seq_cnt_r != '0) begin
               seq_cnt_r <= seq_cnt_r - 1'b1;
            end else if (sweep_run_r && !last_ch) begin
               state_r   <= AISC_GAP;
               seq_cnt_r <= ctrl_r.spacing
                  ? aisc_pkg::CNT_W'(aisc_pkg::SPACE_FAST_CYC - aisc_pkg::CONV_CYC - 1)
                  : aisc_pkg::CNT_W'(aisc_pkg::SPACE_SLOW_CYC - aisc_pkg::CONV_CYC - 1);
            end else begin
               state_r <= AISC_IDLE;
            end
            AISC_GAP: if (seq_cnt_r != '0) begin
               seq_cnt_r <= seq_cnt_r - 1'b1;
            end else begin
               state_r   <= AISC_CONV;
               seq_cnt_r <= aisc_pkg::CNT_W'(aisc_pkg::CONV_CYC - 1);
            end
         endcase
      end
   end

   // Channel pointer; a sweep always begins at the low channel
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ptr_r <= '0;
      else if (wr_chan)
         ptr_r <= w_data_r[3:0];
      else if (start_req && ctrl_r.sweep)
         ptr_r <= chan_r.low;
      else if (conv_end)
         ptr_r <= ptr_nxt;
   end

   // Converter pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_start  <= 1'b0;
         adc_channel <= '0;
         gain_mult   <= 4'h1;
      end else begin
         conv_start  <= (state_r == AISC_IDLE && start_req) ||
                        (state_r == AISC_GAP && seq_cnt_r == '0);
         adc_channel <= (start_req && ctrl_r.sweep) ? chan_r.low : ptr_r;
         gain_mult   <= 4'h1 << ctrl_r.gain;
      end
   end

   // ==========================================================
   // Sample buffer with sticky overrun
   logic [SAMPLE_W-1:0] buf_mem [BUF_DEPTH];
   logic [PW-1:0]       wr_ptr_r, rd_ptr_r;
   logic [PW:0]         fill_r;
   logic                overrun_r, buf_reset, push, pop, full;
   assign buf_reset = wr_cmd && w_data_r[aisc_pkg::CMD_BUF_RESET];
   assign full      = fill_r == (PW+1)'(BUF_DEPTH);
   assign push      = conv_end && !full && !overrun_r && !buf_reset;
   assign pop       = s_axi_arvalid && s_axi_arready && rd_idx == aisc_pkg::IDX_DATA &&
                      fill_r != '0 && !buf_reset;

   always_ff @(posedge aclk) begin
      if (push)
         buf_mem[wr_ptr_r] <= smp_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || buf_reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         fill_r   <= '0;
      end else begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         fill_r <= fill_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         overrun_r <= 1'b0;
      else if (conv_end && full)
         overrun_r <= 1'b1;
      else if (buf_reset)
         overrun_r <= 1'b0;
   end

   // ==========================================================
   // Output converter update
   logic [aisc_pkg::CNT_W-1:0] out_cnt_r;
   logic                       out_busy;
   assign out_busy = out_cnt_r != '0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_cnt_r <= '0;
         out_value <= '0;
         out_load  <= 1'b0;
      end else begin
         out_load <= 1'b0;
         if (wr_out && !out_busy) begin
            out_cnt_r <= aisc_pkg::CNT_W'(aisc_pkg::OUT_BUSY_CYC);
            out_value <= w_data_r[SAMPLE_W-1:0];
            out_load  <= 1'b1;
         end else if (out_busy) begin
            out_cnt_r <= out_cnt_r - 1'b1;
         end
      end
   end

   // ==========================================================
   // Interrupts: set wins over a write-one clear
   logic [aisc_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
   logic                       settle_end, out_end;
   assign settle_end = settle_cnt_r == aisc_pkg::CNT_W'(1) && !(wr_chan || wr_ctrl);
   assign out_end    = out_cnt_r == aisc_pkg::CNT_W'(1);
   always_comb begin
      irq_set                        = '0;
      irq_set[aisc_pkg::IRQ_DONE]    = run_end;
      irq_set[aisc_pkg::IRQ_OVERRUN] = conv_end && full && !overrun_r;
      irq_set[aisc_pkg::IRQ_SETTLED] = settle_end;
      irq_set[aisc_pkg::IRQ_OUT]     = out_end;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         irq        <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~(wr_istat ? w_data_r[aisc_pkg::IRQ_W-1:0] : '0))
                       | irq_set;
         if (wr_imask)
            irq_mask_r <= w_data_r[aisc_pkg::IRQ_W-1:0];
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ==========================================================
   // Read channel
   aisc_pkg::aisc_status_t status;
   always_comb begin
      status.busy     = state_r != AISC_IDLE;
      status.input_config_indicator  = se_r;
      status.settling = settling;
      status.out_busy = out_busy;
      status.overrun  = overrun_r;
      status.sweep    = ctrl_r.sweep;
      status.gain     = ctrl_r.gain;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= aisc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= rd_ok ? aisc_pkg::RESP_OKAY : aisc_pkg::RESP_SLVERR;
            unique case (rd_idx)
               aisc_pkg::IDX_CHAN:     s_axi_rdata <= {24'h0, chan_r};
               aisc_pkg::IDX_STATUS:   s_axi_rdata <= {24'h0, status};
               aisc_pkg::IDX_CTRL:     s_axi_rdata <= {28'h0, ctrl_r};
               aisc_pkg::IDX_IRQ_STAT: s_axi_rdata <= 32'(irq_stat_r);
               aisc_pkg::IDX_IRQ_MASK: s_axi_rdata <= 32'(irq_mask_r);
               aisc_pkg::IDX_DATA:     s_axi_rdata <= 32'(buf_mem[rd_ptr_r]);
               default:                s_axi_rdata <= '0;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Checks
   // Own count of cycles since the last range or gain write, to time settling
   logic [aisc_pkg::CNT_W-1:0] settle_age_r;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         settle_age_r <= '0;
      else if (wr_chan || wr_ctrl)
         settle_age_r <= aisc_pkg::CNT_W'(1);
      else if (settle_age_r != '0 && settle_age_r != '1)
         settle_age_r <= settle_age_r + 1'b1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_settle_raised: assert property (wr_chan |=> settling [*8])
      else $error("settling not raised after range write");
   a_settle_restart: assert property (
      wr_ctrl |=> settle_cnt_r == aisc_pkg::CNT_W'(aisc_pkg::SETTLE_CYC))
      else $error("settling not restarted by gain write");
   a_settle_length: assert property (
      settling == (settle_age_r != '0 && settle_age_r <= aisc_pkg::CNT_W'(aisc_pkg::SETTLE_CYC)))
      else $error("settling interval wrong");
   a_gain_decode: assert property (##1 gain_mult == 4'h1 << $past(ctrl_r.gain))
      else $error("gain multiplier wrong");
   a_busy_start: assert property (start_req |=> status.busy [*8])
      else $error("busy missing during conversion");
   a_single_end: assert property (conv_end && !sweep_run_r |=> !status.busy)
      else $error("busy held after single conversion");
   a_sweep_busy: assert property ($fell(status.busy) |-> $past(run_end))
      else $error("busy dropped inside sweep");
   a_gap_fast: assert property ($rose(state_r == AISC_GAP) && ctrl_r.spacing
      |-> (state_r == AISC_GAP) [*8] ##[1:30] conv_start)
      else $error("fast spacing wrong");
   a_overrun_refuse: assert property (overrun_r && !buf_reset |=> wr_ptr_r == $past(wr_ptr_r))
      else $error("sample taken after overrun");
   a_overrun_sticky: assert property (overrun_r && !buf_reset |=> overrun_r)
      else $error("overrun flag lost");
   a_ptr_low: assert property (wr_chan |=> ptr_r == chan_r.low)
      else $error("pointer not reset to low channel");
   a_readback: assert property (status[2:0] == {ctrl_r.sweep, ctrl_r.gain})
      else $error("readback mismatch");
   a_out_refuse: assert property (out_busy && wr_out |=> !out_load)
      else $error("output write accepted while busy");
endmodule

`default_nettype wire

// ===== shared/aisc_pkg.sv
// Package for the analog input status and settling control block.
// Assumes a single 25 MHz logic clock; every time is converted to cycles here.
`default_nettype none
package aisc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_NS         = 40;
   localparam int SETTLE_NS      = 10000;
   localparam int SPACE_SLOW_NS  = 10000;
   localparam int SPACE_FAST_NS  = 5000;
   localparam int CONV_NS        = 4000;
   localparam int OUT_BUSY_NS    = 3000;
   localparam int SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SPACE_SLOW_CYC = (SPACE_SLOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int SPACE_FAST_CYC = (SPACE_FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYC       = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int OUT_BUSY_CYC   = (OUT_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W          = 16;

   // ==========================================================
   // Register map (printed offsets are indexes; byte address is index times four)
   localparam int          ADDR_W        = 6;
   localparam logic [3:0]  IDX_CHAN      = 4'h2;
   localparam logic [3:0]  IDX_STATUS    = 4'h3;
   localparam logic [3:0]  IDX_CTRL      = 4'h4;
   localparam logic [3:0]  IDX_CMD       = 4'h5;
   localparam logic [3:0]  IDX_IRQ_STAT  = 4'h6;
   localparam logic [3:0]  IDX_IRQ_MASK  = 4'h7;
   localparam logic [3:0]  IDX_DATA      = 4'h8;
   localparam logic [3:0]  IDX_OUT_DATA  = 4'h9;

   // Command register bits
   localparam int CMD_START     = 0;
   localparam int CMD_BUF_RESET = 1;

   // Interrupt status bits
   localparam int IRQ_W       = 4;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_OVERRUN = 1;
   localparam int IRQ_SETTLED = 2;
   localparam int IRQ_OUT     = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Field layouts
   typedef struct packed {
      logic [3:0] high;
      logic [3:0] low;
   } aisc_chan_t;

   typedef struct packed {
      logic       spacing;
      logic       sweep;
      logic [1:0] gain;
   } aisc_ctrl_t;

   typedef struct packed {
      logic       busy;
      logic       input_config_indicator;
      logic       settling;
      logic       out_busy;
      logic       overrun;
      logic       sweep;
      logic [1:0] gain;
   } aisc_status_t;

   localparam aisc_chan_t CHAN_RST = 8'h00;
   localparam aisc_ctrl_t CTRL_RST = 4'h0;
   localparam logic       SE_RST   = 1'b1;
endpackage
`default_nettype wire

// ===== verification/adc_input_status_control_tb_top.sv
// Bench for the analog input status block: AXI4-Lite host tasks and converter model.
// Assumes a 25 MHz clock and a buffer depth of four to reach overrun quickly.
`timescale 1ns/1ps
`default_nettype none
module adc_input_status_control_tb_top;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [5:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, conv_start, out_load, irq, se;
   logic [3:0] adc_channel, gain_mult, lo;
   logic [15:0] adc_sample, out_value;
   int miscompares = 0, n_checks = 0, cyc = 0, seed = 32'h7e262662, v;
   int n_start = 0, n_load = 0, last_start = 0, gap = 0;
   always #20 aclk = ~aclk;
   aisc_conv_model model (.adc_channel(adc_channel), .adc_sample(adc_sample), .input_config_indicator_pin(se));
   aisc_top #(.BUF_DEPTH(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .adc_sample(adc_sample),
      .input_config_indicator_pin(se), .conv_start(conv_start), .adc_channel(adc_channel),
      .gain_mult(gain_mult), .out_value(out_value), .out_load(out_load), .irq(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Each channel drops its valid on the edge where it is taken
   task automatic wr(input logic [5:0] a, input logic [31:0] dat);
      @(posedge aclk);
      awaddr <= a; wdata <= dat; awv <= 1; wv <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awv && awready) awv <= 0;
         if (wv && wready) wv <= 0;
      end while (bvalid !== 1'b1);
      r = bresp; bready <= 0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge aclk);
      araddr <= a; arv <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arv && arready) arv <= 0;
      end while (rvalid !== 1'b1);
      d = rdata; r = rresp; rready <= 0;
   endtask
   // Busy is expected across a sweep; the 260-cycle waits leave 10 cycles of slack beyond the settle count
   task automatic start_conv(); wr(6'h14, 32'h1); endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (conv_start === 1'b1) begin
         n_start    <= n_start + 1;
         gap        <= cyc - last_start;
         last_start <= cyc;
      end
      if (out_load === 1'b1) n_load <= n_load + 1;
      if (cyc == 30000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      rd(6'h0c); chk(d[7:0], 8'h40);
      chk(gain_mult, 4'h1);
      wr(6'h3c, 32'h1); chk(r, aisc_pkg::RESP_SLVERR);
      rd(6'h3c); chk(r, aisc_pkg::RESP_SLVERR);
      wr(6'h0c, 32'h1); chk(r, aisc_pkg::RESP_SLVERR);
      for (int g = 0; g < 4; g++) begin
         v = $random(seed);
         wr(6'h10, {28'h0, v[3:2], g[1:0]});
         rd(6'h0c); chk(d[2:0], {v[2], g[1:0]});
         chk(gain_mult, 4'h1 << g);
      end
      $display("gain and readback test done");
      lo = 4'($random(seed) & 7);
      wr(6'h08, {24'h0, lo + 4'h2, lo});
      repeat (240) @(posedge aclk);
      rd(6'h0c); chk(d[5], 1'b1);
      repeat (10) @(posedge aclk);
      rd(6'h0c); chk(d[5], 1'b0);
      wr(6'h10, 32'h0); repeat (200) @(posedge aclk);
      wr(6'h10, 32'hc); repeat (200) @(posedge aclk);
      rd(6'h0c); chk(d[5], 1'b1);
      repeat (60) @(posedge aclk);
      rd(6'h0c); chk(d[5], 1'b0);
      wr(6'h10, 32'h0); wr(6'h08, {24'h0, lo + 4'h2, lo}); repeat (260) @(posedge aclk);
      start_conv();
      rd(6'h0c); chk(d[7], 1'b1);
      chk(adc_channel, lo);
      repeat (110) @(posedge aclk);
      rd(6'h0c); chk(d[7], 1'b0);
      rd(6'h20); chk(d[15:0], {12'h5a3, lo});
      chk(n_start, 1);
      $display("settling and single test done");
      wr(6'h1c, 32'h0); wr(6'h10, 32'hc); wr(6'h08, 32'h20); repeat (260) @(posedge aclk);
      start_conv(); repeat (200) @(posedge aclk);
      rd(6'h0c); chk(d[7], 1'b1);
      repeat (200) @(posedge aclk);
      rd(6'h0c); chk(d[7:3], 5'h08);
      chk(n_start, 4);
      chk(gap, aisc_pkg::SPACE_FAST_CYC);
      start_conv(); repeat (420) @(posedge aclk);
      rd(6'h0c); chk(d[3], 1'b1);
      chk(irq, 1'b0);
      wr(6'h1c, 32'h2); repeat (3) @(posedge aclk); chk(irq, 1'b1);
      wr(6'h18, 32'h2); repeat (3) @(posedge aclk); chk(irq, 1'b0);
      rd(6'h20); rd(6'h0c); chk(d[3], 1'b1);
      wr(6'h14, 32'h2);
      rd(6'h0c); chk(d[3], 1'b0);
      wr(6'h10, 32'h4); repeat (260) @(posedge aclk);
      start_conv(); repeat (700) @(posedge aclk);
      chk(n_start, 10);
      chk(gap, aisc_pkg::SPACE_SLOW_CYC);
      $display("sweep and overrun test done");
      wr(6'h24, 32'h1234);
      rd(6'h0c); chk(d[4], 1'b1);
      wr(6'h24, 32'h5678);
      chk(out_value, 16'h1234);
      chk(n_load, 1);
      repeat (80) @(posedge aclk);
      rd(6'h0c); chk(d[4], 1'b0);
      $display("output busy test done");
      complete_run();
   end
endmodule
`default_nettype wire

// ===== verification/aisc_conv_model.sv
// Converter model: answers on the sample pins with a value tied to the channel.
// Assumes the block drives the channel select as a steady level during a conversion.
`timescale 1ns/1ps
`default_nettype none
module aisc_conv_model (
   // Converter side
   input  wire logic [3:0]  adc_channel,
   output logic [15:0]      adc_sample,
   output logic             input_config_indicator_pin
);
   // Channel in the low nibble, so a wrong pointer shows in the data
   assign adc_sample  = {12'h5a3, adc_channel};
   assign input_config_indicator_pin = 1'b1;
endmodule
`default_nettype wire
